// file: design/enc_ctrl_pkg.sv
/*
 package for the encoder test and key control block: register offsets, field positions,
 reset values and limits.
 assumes a 32-bit apb slave with one register per aligned word.
*/
package enc_ctrl_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_TEST_CONTROL = 8'h03;
    localparam logic [7:0] IDX_KEY_CONTROL = 8'h04;
    localparam logic [7:0] IDX_TEST_WORD = 8'h40;
    localparam logic [7:0] IDX_LAYOUT_CTRL = 8'h01;
    localparam logic [7:0] IDX_FIELD_STATUS = 8'h60;
    localparam logic [11:0] ADDR_TEST_CONTROL = {2'b00, IDX_TEST_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_KEY_CONTROL = {2'b00, IDX_KEY_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_TEST_WORD = {2'b00, IDX_TEST_WORD, 2'b00};
    localparam logic [11:0] ADDR_LAYOUT_CTRL = {2'b00, IDX_LAYOUT_CTRL, 2'b00};
    localparam logic [11:0] ADDR_FIELD_STATUS = {2'b00, IDX_FIELD_STATUS, 2'b00};
    // test control fields
    localparam int B_LIMITER = 6;
    localparam int B_TEST_ON = 5;
    localparam int B_HOLD = 4;
    localparam int B_UPPER = 3;
    localparam int B_LUMA_TST = 2;
    localparam int B_FREERUN = 1;
    localparam int B_CHROMA_TST = 0;
    // key control fields, then the layout control field
    localparam int B_LAYER_ASSIGN_SEL_MSB = 7;
    localparam int B_HW_KEY = 6;
    localparam int B_BURST_GL = 5;
    localparam int B_KEY_BLANK = 4;
    localparam int B_CH1_OFF = 3;
    localparam int B_CH2_OFF = 2;
    localparam int B_CH3_OFF = 1;
    localparam int B_DATA_KEY = 0;
    localparam int B_LAYOUT_ON = 6;
    localparam logic [7:0] RESET_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RESET_KEY_CONTROL = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h7f;
    localparam logic [7:0] LAYOUT_MASK = 8'h40;
    // 101 ire in 10-bit luma code
    localparam logic [9:0] LUMA_LIMIT = 10'h3_2c;
    localparam logic [2:0] LAST_FIELD = 3'h7;
endpackage : enc_ctrl_pkg

// file: design/encoder_test_and_key_control.sv
/*
 test and key control registers of a video encoder with their datapath effects:
 luma limiter, d/a test sourcing, subcarrier reload cadence, keying decisions.
 assumes apb master on pclk; pclk is the pixel clock; field_end pulses once per field.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module encoder_test_and_key_control
    import enc_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] luma_in,
    input wire logic [9:0] chroma_in,
    input wire logic [9:0] composite_in,
    input wire logic field_end,
    input wire logic hw_key_pin,
    input wire logic active_video,
    input wire logic [23:0] pixel,
    input wire logic [23:0] key_value,
    input wire logic [7:0] genlock_burst,
    input wire logic [7:0] internal_burst,
    output logic [9:0] luma_dac,
    output logic [9:0] chroma_dac,
    output logic [9:0] luma_to_mod,
    output logic [7:0] burst_out,
    output logic key_active,
    output logic subcarrier_reload,
    output logic [3:0] layer_assign_sel
);
    logic [7:0] test_control;
    logic [7:0] key_control;
    logic [7:0] layout_ctrl;
    logic [9:0] dac_test_word;
    logic [9:0] captured_word;
    logic test_phase_upper;
    logic [2:0] field_count;
    logic reload_armed;
    logic match;
    logic next_key;
    logic [9:0] test_drive;

    logic luma_limiter_on;
    logic dac_test_on;
    logic test_half_hold;
    logic test_upper_half_sel;
    logic luma_dac_test_src;
    logic subcarrier_freerun;
    logic chroma_dac_test_src;
    logic layering_layout_on;
    logic hw_key_on;
    logic burst_from_genlock;
    logic key_in_blanking;
    logic data_key_on;
    logic [2:0] chan_off;

    logic wr_en;
    logic rd_en;
    logic upper_now;

    assign luma_limiter_on = test_control[B_LIMITER];
    assign dac_test_on = test_control[B_TEST_ON];
    assign test_half_hold = test_control[B_HOLD];
    assign test_upper_half_sel = test_control[B_UPPER];
    assign luma_dac_test_src = test_control[B_LUMA_TST];
    assign subcarrier_freerun = test_control[B_FREERUN];
    assign chroma_dac_test_src = test_control[B_CHROMA_TST];
    assign layering_layout_on = layout_ctrl[B_LAYOUT_ON];
    assign hw_key_on = key_control[B_HW_KEY];
    assign burst_from_genlock = key_control[B_BURST_GL];
    assign key_in_blanking = key_control[B_KEY_BLANK];
    assign data_key_on = key_control[B_DATA_KEY];
    // channel disables only meaningful in key layout
    assign chan_off = layering_layout_on ? 3'b000 :
                      {key_control[B_CH1_OFF], key_control[B_CH2_OFF], key_control[B_CH3_OFF]};

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // which half is presented this pixel
    assign upper_now = test_half_hold ? test_upper_half_sel : test_phase_upper;

    // half mapping: upper = 8 msbs on bits 7-0, lower = 2 lsbs on bits 1-0
    function automatic logic [9:0] merge_half(input logic [9:0] cur, input logic [7:0] d,
                                              input logic up);
        merge_half = up ? {d, cur[1:0]} : {cur[9:2], d[1:0]};
    endfunction : merge_half

    function automatic logic [7:0] pick_half(input logic [9:0] w, input logic up);
        pick_half = up ? w[9:2] : {6'h00, w[1:0]};
    endfunction : pick_half

    key_match u_match (
        .pixel(pixel),
        .key_value(key_value),
        .chan_off(chan_off),
        .match(match)
    );

    // apb answers in the access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~(paddr == ADDR_TEST_CONTROL ||
                       paddr == ADDR_KEY_CONTROL || paddr == ADDR_TEST_WORD ||
                       paddr == ADDR_LAYOUT_CTRL || paddr == ADDR_FIELD_STATUS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_control <= RESET_TEST_CONTROL;
        end else if (wr_en && pready && paddr == ADDR_TEST_CONTROL) begin
            test_control <= pwdata[7:0] & REG_MASK;
        end
    end

    // same storage for both layouts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_control <= RESET_KEY_CONTROL;
        end else if (wr_en && pready && paddr == ADDR_KEY_CONTROL) begin
            key_control <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            layout_ctrl <= RESET_KEY_CONTROL;
        end else if (wr_en && pready && paddr == ADDR_LAYOUT_CTRL) begin
            layout_ctrl <= pwdata[7:0] & LAYOUT_MASK;
        end
    end

    // test word writes go to the selected half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_test_word <= 10'h000;
        end else if (wr_en && pready && paddr == ADDR_TEST_WORD && dac_test_on) begin
            dac_test_word <= merge_half(dac_test_word, pwdata[7:0], upper_now);
        end
    end

    // composite sampled for test reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_word <= 10'h000;
        end else begin
            captured_word <= composite_in;
        end
    end

    // half alternation at pixel rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_phase_upper <= 1'b1;
        end else if (dac_test_on && !test_half_hold) begin
            test_phase_upper <= ~test_phase_upper;
        end else begin
            test_phase_upper <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && pwrite) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                ADDR_TEST_CONTROL: prdata <= {24'h00_0000, test_control};
                ADDR_KEY_CONTROL: prdata <= {24'h00_0000, key_control};
                ADDR_LAYOUT_CTRL: prdata <= {24'h00_0000, layout_ctrl};
                ADDR_TEST_WORD: prdata <= dac_test_on ?
                    {24'h00_0000, pick_half(captured_word, upper_now)} : 32'h0000_0000;
                ADDR_FIELD_STATUS: prdata <= {28'h000_0000, reload_armed, field_count};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // eight-field cadence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            field_count <= 3'h0;
            reload_armed <= 1'b1;
            subcarrier_reload <= 1'b0;
        end else begin
            subcarrier_reload <= 1'b0;
            if (field_end) begin
                field_count <= field_count + 3'h1;
                if (field_count == LAST_FIELD) begin
                    // first eighth field after reset always reloads
                    subcarrier_reload <= reload_armed | ~subcarrier_freerun;
                    reload_armed <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        test_drive = dac_test_word;
    end

    // d/a sourcing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            luma_dac <= 10'h000;
            chroma_dac <= 10'h000;
        end else begin
            luma_dac <= (dac_test_on && luma_dac_test_src) ? test_drive : luma_in;
            chroma_dac <= (dac_test_on && chroma_dac_test_src) ? test_drive : chroma_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            luma_to_mod <= 10'h000;
        end else if (luma_limiter_on && luma_in > LUMA_LIMIT) begin
            luma_to_mod <= LUMA_LIMIT;
        end else begin
            luma_to_mod <= luma_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_out <= 8'h00;
        end else begin
            burst_out <= burst_from_genlock ? genlock_burst : internal_burst;
        end
    end

    always_comb begin
        next_key = 1'b0;
        if (hw_key_on && hw_key_pin) begin
            next_key = 1'b1;
        end
        if (data_key_on && match && (active_video || key_in_blanking)) begin
            next_key = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_active <= 1'b0;
        end else begin
            key_active <= next_key;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            layer_assign_sel <= 4'h0;
        end else if (layering_layout_on) begin
            layer_assign_sel <= {key_control[B_LAYER_ASSIGN_SEL_MSB], key_control[3:1]};
        end else begin
            layer_assign_sel <= 4'h0;
        end
    end
endmodule : encoder_test_and_key_control

// file: design/key_match.sv
/*
 data key match for three colour channels.
 assumes key values and pixel data on the same clock.
*/
`timescale 1ns/1ps
module key_match
    import enc_ctrl_pkg::*;
(
    input wire logic [23:0] pixel,
    input wire logic [23:0] key_value,
    input wire logic [2:0] chan_off,
    output logic match
);
    function automatic logic chan_hit(input logic [7:0] a, input logic [7:0] b, input logic off);
        chan_hit = off | (a == b);
    endfunction : chan_hit

    // disabled channels always count as matched
    assign match = chan_hit(pixel[23:16], key_value[23:16], chan_off[2]) &
                   chan_hit(pixel[15:8], key_value[15:8], chan_off[1]) &
                   chan_hit(pixel[7:0], key_value[7:0], chan_off[0]);
endmodule : key_match

// file: dv/enc_ctrl_assertions.sv
/*
 port checker for the encoder test and key control block.
 assumes binding to the top module; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module enc_ctrl_assertions
    import enc_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [9:0] luma_in,
    input wire logic [9:0] luma_to_mod,
    input wire logic field_end,
    input wire logic subcarrier_reload,
    input wire logic [7:0] genlock_burst,
    input wire logic [7:0] internal_burst,
    input wire logic [7:0] burst_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    answer_one_cycle_a: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stood more than one cycle");
    err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without ready or with data");
    read_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read upper bits not zero");
    luma_limit_a: assert property ($past(presetn) |-> luma_to_mod == $past(luma_in) ||
        (luma_to_mod == LUMA_LIMIT && $past(luma_in) > LUMA_LIMIT))
        else $error("luma to modulator neither passed nor clamped");
    reload_single_a: assert property (subcarrier_reload |=> !subcarrier_reload)
        else $error("reload pulse too long");
    reload_cause_a: assert property (subcarrier_reload |-> $past(field_end))
        else $error("reload without field end");
    burst_src_a: assert property ($past(presetn) |-> burst_out == $past(genlock_burst) ||
        burst_out == $past(internal_burst))
        else $error("burst from neither source");
    cover property (subcarrier_reload);
    cover property (pslverr);
    cover property (luma_to_mod == LUMA_LIMIT);
endmodule : enc_ctrl_assertions

bind encoder_test_and_key_control enc_ctrl_assertions u_enc_ctrl_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .luma_in(luma_in), .luma_to_mod(luma_to_mod),
    .field_end(field_end), .subcarrier_reload(subcarrier_reload),
    .genlock_burst(genlock_burst), .internal_burst(internal_burst), .burst_out(burst_out));

// file: dv/encoder_test_and_key_control_test.sv
/*
 self-checking bench for the encoder test and key control block.
 assumes the host model for apb; bench drives the video side itself.
*/
`timescale 1ns/1ps
module encoder_test_and_key_control_test;
    import enc_ctrl_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] luma_in = 10'h3ff, chroma_in = 10'h155, composite_in = 10'h2aa;
    logic field_end = 1'b0, hw_key_pin = 1'b0, active_video = 1'b1, key_active, reload;
    logic [23:0] pixel = 24'h12_3456, key_value = 24'h12_3456;
    logic [7:0] genlock_burst = 8'h22, internal_burst = 8'h11, burst_out;
    logic [9:0] luma_dac, chroma_dac, luma_to_mod;
    logic [3:0] layer_sel;
    int err_total = 0, n_compared = 0, n_reload = 0;
    host_apb_model u_host_apb_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    encoder_test_and_key_control u_encoder_test_and_key_control (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .luma_in(luma_in), .chroma_in(chroma_in), .composite_in(composite_in),
        .field_end(field_end), .hw_key_pin(hw_key_pin), .active_video(active_video),
        .pixel(pixel), .key_value(key_value), .genlock_burst(genlock_burst),
        .internal_burst(internal_burst), .luma_dac(luma_dac), .chroma_dac(chroma_dac),
        .luma_to_mod(luma_to_mod), .burst_out(burst_out), .key_active(key_active),
        .subcarrier_reload(reload), .layer_assign_sel(layer_sel));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (reload === 1'b1) n_reload <= n_reload + 1;
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        u_host_apb_model.xfer(1'b1, a, {24'h00_0000, d}, r, e);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err, input string n);
        logic [31:0] r;
        logic e;
        u_host_apb_model.xfer(1'b0, a, 32'h0000_0000, r, e);
        check(n, exp, r);
        check("slave error", {31'h0, exp_err}, {31'h0, e});
    endtask : rd
    task settle;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task fields(input int n);
        repeat (n) begin
            @(posedge pclk);
            field_end <= 1'b1;
            @(posedge pclk);
            field_end <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        settle();
    endtask : fields
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_TEST_CONTROL, 32'h0, 1'b0, "test_control");
        rd(ADDR_KEY_CONTROL, 32'h0, 1'b0, "key_control");
        fields(8);
        check("reload after reset", 1, n_reload);
        wr(ADDR_TEST_CONTROL, 8'h02);
        fields(8);
        check("reload freerun", 1, n_reload);
        wr(ADDR_TEST_CONTROL, 8'h00);
        fields(8);
        check("reload cadence", 2, n_reload);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_TEST_CONTROL, 32'h0, 1'b0, "test_control after reset");
        wr(ADDR_TEST_CONTROL, 8'h02);
        fields(8);
        check("reload after second reset", 3, n_reload);
        $display("test reload done");
        wr(ADDR_TEST_CONTROL, 8'hff);
        rd(ADDR_TEST_CONTROL, 32'h7f, 1'b0, "reserved bit");
        rd(12'h0f0, 32'h0, 1'b1, "unmapped");
        wr(ADDR_TEST_CONTROL, 8'h40);
        settle();
        check("luma clamped", LUMA_LIMIT, luma_to_mod);
        wr(ADDR_TEST_CONTROL, 8'h00);
        settle();
        check("luma passed", 10'h3ff, luma_to_mod);
        wr(ADDR_TEST_CONTROL, 8'h3c);
        wr(ADDR_TEST_WORD, 8'hab);
        settle();
        check("luma dac upper", {8'hab, 2'b00}, luma_dac);
        check("chroma dac", 10'h155, chroma_dac);
        wr(ADDR_TEST_CONTROL, 8'h31);
        wr(ADDR_TEST_WORD, 8'h03);
        settle();
        check("chroma dac lower", {8'hab, 2'b11}, chroma_dac);
        check("luma dac normal", 10'h3ff, luma_dac);
        rd(ADDR_TEST_WORD, 32'h02, 1'b0, "test read lower");
        wr(ADDR_TEST_CONTROL, 8'h21);
        wr(ADDR_TEST_WORD, 8'h5a);
        wr(ADDR_TEST_WORD, 8'h00);
        settle();
        check("chroma dac alternating", {8'h5a, 2'b00}, chroma_dac);
        $display("test datapath done");
        wr(ADDR_KEY_CONTROL, 8'h20);
        settle();
        check("burst genlock", 8'h22, burst_out);
        wr(ADDR_KEY_CONTROL, 8'h00);
        hw_key_pin <= 1'b1;
        settle();
        check("burst internal", 8'h11, burst_out);
        check("hw key ignored", 0, key_active);
        wr(ADDR_KEY_CONTROL, 8'h40);
        settle();
        check("hw key used", 1, key_active);
        wr(ADDR_KEY_CONTROL, 8'h01);
        hw_key_pin <= 1'b0;
        settle();
        check("data key", 1, key_active);
        wr(ADDR_KEY_CONTROL, 8'h00);
        settle();
        check("data key off", 0, key_active);
        wr(ADDR_KEY_CONTROL, 8'h01);
        active_video <= 1'b0;
        settle();
        check("key in blanking", 0, key_active);
        wr(ADDR_KEY_CONTROL, 8'h11);
        settle();
        check("key window wide", 1, key_active);
        wr(ADDR_KEY_CONTROL, 8'h11);
        pixel <= 24'hff_3456;
        settle();
        check("chan1 mismatch", 0, key_active);
        wr(ADDR_KEY_CONTROL, 8'h19);
        settle();
        check("chan1 off", 1, key_active);
        $display("test keying done");
        wr(ADDR_KEY_CONTROL, 8'h8a);
        wr(ADDR_LAYOUT_CTRL, 8'h40);
        settle();
        check("layer select", 4'hd, layer_sel);
        wr(ADDR_LAYOUT_CTRL, 8'h00);
        rd(ADDR_KEY_CONTROL, 32'h8a, 1'b0, "key kept");
        settle();
        check("layer off", 4'h0, layer_sel);
        $display("test layering done");
        print_verdict();
    end
endmodule : encoder_test_and_key_control_test

// file: dv/host_apb_model.sv
/*
 host microprocessor model: apb master with one transfer task.
 assumes the task is entered from the bench; changes all signals after rising edges.
*/
`timescale 1ns/1ps
module host_apb_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // setup, access until ready, then release
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d[7:0]};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : host_apb_model
